// ### core/drive_port_select_decoder.sv
// How it works
// [RULE1] Upper enable: wide mode, flag low, cmd range
// [RULE2] Upper enable never asserted in narrow mode
// [RULE3] Command select: cmd range, or 320H-323H narrow
// [RULE4] Control select: 3F6/3F7 or 376/377 ranges
// [RULE5] Wide flag low means sixteen-bit transfer
// [RULE6] Narrow mode: flag pin is DMA ack
// [RULE7] Bit 7 buffered: cmd, 3F6 both ways, 3F7 write
// [RULE8] Read of 3F7 returns disk-change bit
// [RULE9] Narrow mode: bit-7 path stays idle
// [RULE10] Address strap latched at reset, then held
// [RULE11] Lower enable: cmd/ctl ranges in wide mode, 320H-323H or DMA in narrow
// [RULE12] Disabled port keeps selects and enables off
`default_nettype none

module drive_port_select_decoder (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Configuration
    input wire logic port_enable,
    input wire logic sixteen_bit_host_mode,
    input wire logic drive_addr_strap,
    // Host bus address and strobes
    input wire logic [dpsd_pkg::DPSD_ADDR_W-1:0] host_addr,
    input wire logic host_aen,
    input wire logic host_ior_n,
    input wire logic host_iow_n,
    // Host data bit 7, two-way
    input wire logic host_d7_in,
    output logic host_d7_out,
    output logic host_d7_oe_n,
    // Floppy disk-change status
    input wire logic disk_change,
    // Drive side flag pin, shared with DMA acknowledge
    input wire logic wide_transfer_flag_n,
    // Drive selects and byte enables
    output logic drive_cmd_select_n,
    output logic drive_ctl_select_n,
    output logic drive_upper_byte_enable_n,
    output logic drive_lower_byte_enable_n,
    // Drive data bit 7, two-way
    input wire logic drive_data_bit7_in,
    output logic drive_data_bit7_out,
    output logic drive_data_bit7_oe_n,
    // Status
    output logic secondary_set
);
    import dpsd_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Each window compares only the address bits above its size
    dpsd_match_if match_bus ();  // Carrier to the decoder

    assign match_bus.addr = host_addr;
    // Only CPU cycles decode; DMA cycles raise AEN
    assign match_bus.addr_valid = !host_aen;

    dpsd_addr_match u_match (
        .bus (match_bus.decoder)
    );

    // ------------------------------------------------------------
    // Reset-time strap sample
    // ------------------------------------------------------------
    logic strap_pin_reg;  // Strap pin level at the last edge in reset
    logic strap_pin_next;

    // Follow the pin only while reset is low, then freeze it
    always_comb begin
        strap_pin_next = strap_pin_reg;
        if (!rst_n) begin
            // The pin may carry other traffic once reset is gone
            strap_pin_next = drive_addr_strap; // [RULE10]
        end
    end

    // Sample flop; no async reset, it must load the pin during reset
    // Reset therefore has to span at least one clock edge
    always_ff @(posedge clock) begin
        strap_pin_reg <= strap_pin_next;
    end

    // ------------------------------------------------------------
    // Strap capture state
    // ------------------------------------------------------------
    dpsd_strap_state_t strap_state_reg; // Capture or run
    dpsd_strap_state_t strap_state_next;
    logic strap_reg;                    // Latched address strap
    logic strap_next;

    // Strap capture next state
    always_comb begin
        strap_state_next = strap_state_reg;
        strap_next = strap_reg;
        case (strap_state_reg)
            DPSD_CAPTURE: begin
                // First edge after release takes the reset-time sample
                strap_next = strap_pin_reg; // [RULE10]
                strap_state_next = DPSD_RUN;
            end
            DPSD_RUN: begin
                // Held until the next reset
                strap_next = strap_reg; // [RULE10]
            end
            default: begin
                strap_state_next = DPSD_CAPTURE;
            end
        endcase
    end

    // Strap capture registers
    // Reset returns to capture and the primary set
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strap_state_reg <= DPSD_CAPTURE;
            strap_reg <= DPSD_STRAP_RESET;
        end else begin
            strap_state_reg <= strap_state_next;
            strap_reg <= strap_next;
        end
    end

    // ------------------------------------------------------------
    // Window qualification
    // ------------------------------------------------------------
    logic use_secondary;  // Secondary address set selected
    logic wide_mode;      // Sixteen-bit host mode
    logic narrow_mode;    // Eight-bit host mode
    logic cmd_hit;        // Command window of the active set
    logic ctl_hit;        // Control window of the active set
    logic ctl_hi;         // Upper control address (3F7/377)
    logic narrow_hit;     // 320H-323H window
    logic wide_xfer;      // Drive asks for a sixteen-bit transfer
    logic dma_ack;        // Drive DMA acknowledge in narrow mode
    logic host_rd;        // Host read strobe
    logic host_wr;        // Host write strobe

    // Decode qualification
    // Narrow mode reads the flag pin as the DMA acknowledge
    always_comb begin
        use_secondary = strap_reg; // [RULE10]
        wide_mode = sixteen_bit_host_mode;
        narrow_mode = !sixteen_bit_host_mode;
        // Strobes are levels; no edge detect is needed
        host_rd = !host_ior_n;
        host_wr = !host_iow_n;
        // Pick the window pair of the strapped address set
        if (use_secondary) begin
            cmd_hit = match_bus.hit[DPSD_HIT_SEC_CMD];
            ctl_hit = match_bus.hit[DPSD_HIT_SEC_CTL];
        end else begin
            cmd_hit = match_bus.hit[DPSD_HIT_PRI_CMD];
            ctl_hit = match_bus.hit[DPSD_HIT_PRI_CTL];
        end
        // Narrow mode uses the primary control pair only
        if (narrow_mode) begin
            ctl_hit = match_bus.hit[DPSD_HIT_PRI_CTL]; // [RULE4]
        end
        ctl_hi = host_addr[DPSD_CTL_SUB_BIT];
        narrow_hit = match_bus.hit[DPSD_HIT_NARROW];
        // Flag pin meaning depends on host mode
        wide_xfer = wide_mode && !wide_transfer_flag_n; // [RULE5]
        dma_ack = narrow_mode && !wide_transfer_flag_n; // [RULE6]
    end

    // ------------------------------------------------------------
    // Select and enable outputs
    // ------------------------------------------------------------
    logic cmd_sel_reg;   // Command select, active low
    logic cmd_sel_next;
    logic ctl_sel_reg;   // Control select, active low
    logic ctl_sel_next;
    logic upper_en_reg;  // Upper byte enable, active low
    logic upper_en_next;
    logic lower_en_reg;  // Lower byte enable, active low
    logic lower_en_next;

    // Registered outputs lag the address by one cycle
    // That keeps the pins free of decode glitches
    // Select next values
    always_comb begin
        // Defaults park every active-low output high
        cmd_sel_next = DPSD_SEL_IDLE;
        ctl_sel_next = DPSD_SEL_IDLE;
        upper_en_next = DPSD_SEL_IDLE;
        lower_en_next = DPSD_SEL_IDLE;
        if (!port_enable) begin
            // Disabled port: everything parked
            cmd_sel_next = DPSD_SEL_IDLE; // [RULE12]
            ctl_sel_next = DPSD_SEL_IDLE; // [RULE12]
            upper_en_next = DPSD_SEL_IDLE; // [RULE12]
            lower_en_next = DPSD_SEL_IDLE; // [RULE12]
        end else if (wide_mode) begin
            // Sixteen-bit host decode
            cmd_sel_next = !cmd_hit; // [RULE3]
            ctl_sel_next = !ctl_hit; // [RULE4]
            upper_en_next = !(cmd_hit && wide_xfer); // [RULE1]
            lower_en_next = !(cmd_hit || ctl_hit); // [RULE11]
        end else begin
            // Eight-bit host decode; upper enable unused
            cmd_sel_next = !narrow_hit; // [RULE3]
            ctl_sel_next = !ctl_hit; // [RULE4]
            upper_en_next = DPSD_SEL_IDLE; // [RULE2]
            lower_en_next = !(narrow_hit || dma_ack); // [RULE11]
        end
    end

    // Select registers
    // Reset parks every select and enable high
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_sel_reg <= DPSD_SEL_IDLE;
            ctl_sel_reg <= DPSD_SEL_IDLE;
            upper_en_reg <= DPSD_SEL_IDLE;
            lower_en_reg <= DPSD_SEL_IDLE;
        end else begin
            cmd_sel_reg <= cmd_sel_next;
            ctl_sel_reg <= ctl_sel_next;
            upper_en_reg <= upper_en_next;
            lower_en_reg <= lower_en_next;
        end
    end

    // ------------------------------------------------------------
    // Data bit 7 buffer
    // ------------------------------------------------------------
    logic host_d7_reg;       // Value driven to the host
    logic host_d7_next;
    logic host_oe_reg;       // Host pin enable, active low
    logic host_oe_next;
    logic drive_d7_reg;      // Value driven to the drive
    logic drive_d7_next;
    logic drive_oe_reg;      // Drive pin enable, active low
    logic drive_oe_next;
    logic buf_active;        // Bit-7 path allowed at all
    logic rd_to_host;        // Drive bit 7 goes to the host
    logic rd_change;         // Disk-change bit goes to the host
    logic wr_to_drive;       // Host bit 7 goes to the drive

    // Read and write strobes are judged independently
    // Bit-7 direction and source
    always_comb begin
        // Only in sixteen-bit mode with the port on
        buf_active = port_enable && wide_mode; // [RULE9]
        rd_to_host = buf_active && host_rd && (cmd_hit || (ctl_hit && !ctl_hi)); // [RULE7]
        rd_change = buf_active && host_rd && ctl_hit && ctl_hi; // [RULE8]
        wr_to_drive = buf_active && host_wr && (cmd_hit || ctl_hit); // [RULE7]
        // Defaults release both bit-7 pins
        host_d7_next = DPSD_DATA_RESET;
        host_oe_next = DPSD_OE_IDLE;
        drive_d7_next = DPSD_DATA_RESET;
        drive_oe_next = DPSD_OE_IDLE;
        if (rd_change) begin
            // Read of the upper control address
            host_d7_next = disk_change; // [RULE8]
            host_oe_next = 1'b0;
        end else if (rd_to_host) begin
            // Drive to host copy
            host_d7_next = drive_data_bit7_in; // [RULE7]
            host_oe_next = 1'b0;
        end
        if (wr_to_drive) begin
            // Host to drive copy
            drive_d7_next = host_d7_in; // [RULE7]
            drive_oe_next = 1'b0;
        end
    end

    // Bit-7 registers
    // Reset releases both bit-7 pins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            host_d7_reg <= DPSD_DATA_RESET;
            host_oe_reg <= DPSD_OE_IDLE;
            drive_d7_reg <= DPSD_DATA_RESET;
            drive_oe_reg <= DPSD_OE_IDLE;
        end else begin
            host_d7_reg <= host_d7_next;
            host_oe_reg <= host_oe_next;
            drive_d7_reg <= drive_d7_next;
            drive_oe_reg <= drive_oe_next;
        end
    end

    // ------------------------------------------------------------
    // Output wiring
    // ------------------------------------------------------------
    // Drive selects and byte enables
    assign drive_cmd_select_n = cmd_sel_reg;
    assign drive_ctl_select_n = ctl_sel_reg;
    assign drive_upper_byte_enable_n = upper_en_reg;
    assign drive_lower_byte_enable_n = lower_en_reg;
    // Host side of bit 7
    assign host_d7_out = host_d7_reg;
    assign host_d7_oe_n = host_oe_reg;
    // Drive side of bit 7
    assign drive_data_bit7_out = drive_d7_reg;
    assign drive_data_bit7_oe_n = drive_oe_reg;
    // Latched address set
    assign secondary_set = strap_reg;

endmodule : drive_port_select_decoder

`default_nettype wire

// ### core/dpsd_pkg.sv
`default_nettype none

package dpsd_pkg;

    // ------------------------------------------------------------
    // Address decode table
    // ------------------------------------------------------------
    // Host I/O address width on the expansion bus
    localparam int DPSD_ADDR_W = 10;
    // Number of decoded address windows
    localparam int DPSD_NUM_RANGES = 5;

    // Window indices into the hit vector
    localparam int DPSD_HIT_PRI_CMD = 0; // 1F0H-1F7H
    localparam int DPSD_HIT_PRI_CTL = 1; // 3F6H-3F7H
    localparam int DPSD_HIT_SEC_CMD = 2; // 170H-177H
    localparam int DPSD_HIT_SEC_CTL = 3; // 376H-377H
    localparam int DPSD_HIT_NARROW = 4;  // 320H-323H

    // Window base addresses, index 0 in the low slot
    localparam logic [DPSD_NUM_RANGES-1:0][DPSD_ADDR_W-1:0] DPSD_MATCH_BASE = {
        10'h320, 10'h376, 10'h170, 10'h3F6, 10'h1F0
    };
    // Low address bits ignored by each window
    localparam logic [DPSD_NUM_RANGES-1:0][1:0] DPSD_MATCH_LOW = {
        2'h2, 2'h1, 2'h3, 2'h1, 2'h3
    };
    // Address bit that splits 3F6/3F7 (and 376/377)
    localparam int DPSD_CTL_SUB_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic DPSD_SEL_IDLE = 1'b1;    // Active-low selects parked high
    localparam logic DPSD_OE_IDLE = 1'b1;     // Active-low enables parked high
    localparam logic DPSD_DATA_RESET = 1'b0;  // Bit-7 data idle value
    localparam logic DPSD_STRAP_RESET = 1'b0; // Primary set until strap taken

    // Strap capture sequencer
    typedef enum logic {
        DPSD_CAPTURE,
        DPSD_RUN
    } dpsd_strap_state_t;

endpackage : dpsd_pkg

`default_nettype wire

// ### core/dpsd_match_if.sv
`default_nettype none

// ------------------------------------------------------------
// Address match carrier between the top and the decoder
// ------------------------------------------------------------
interface dpsd_match_if;
    import dpsd_pkg::*;

    logic [DPSD_ADDR_W-1:0] addr;      // Host address
    logic addr_valid;                  // Address qualifies for I/O decode
    logic [DPSD_NUM_RANGES-1:0] hit;   // One bit per window

    // Top drives address, reads hits
    modport requester (
        output addr,
        output addr_valid,
        input hit
    );
    // Decoder reads address, drives hits
    modport decoder (
        input addr,
        input addr_valid,
        output hit
    );
endinterface : dpsd_match_if

`default_nettype wire

// ### core/dpsd_addr_match.sv
`default_nettype none

module dpsd_addr_match (
    // Match carrier
    dpsd_match_if.decoder bus
);
    import dpsd_pkg::*;

    // ------------------------------------------------------------
    // One comparator per window
    // ------------------------------------------------------------
    for (genvar i = 0; i < DPSD_NUM_RANGES; i++) begin : g_rng
        // Compare only the bits above the window's low bits
        assign bus.hit[i] = bus.addr_valid
            && ((bus.addr >> DPSD_MATCH_LOW[i]) == (DPSD_MATCH_BASE[i] >> DPSD_MATCH_LOW[i]));
    end

endmodule : dpsd_addr_match

`default_nettype wire

// ### sim/dpsd_checker_sva.sv
`default_nettype none

module dpsd_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Watched inputs
    input wire logic port_enable,
    input wire logic sixteen_bit_host_mode,
    input wire logic [dpsd_pkg::DPSD_ADDR_W-1:0] host_addr,
    input wire logic host_aen,
    input wire logic host_ior_n,
    input wire logic host_iow_n,
    input wire logic host_d7_in,
    input wire logic disk_change,
    input wire logic wide_transfer_flag_n,
    input wire logic drive_data_bit7_in,
    // Watched outputs
    input wire logic host_d7_out,
    input wire logic host_d7_oe_n,
    input wire logic drive_cmd_select_n,
    input wire logic drive_ctl_select_n,
    input wire logic drive_upper_byte_enable_n,
    input wire logic drive_lower_byte_enable_n,
    input wire logic drive_data_bit7_out,
    input wire logic drive_data_bit7_oe_n,
    input wire logic secondary_set
);
    import dpsd_pkg::*;
    logic [1:0] up_reg; // Edges since reset release
    logic [1:0] up_next;
    logic wide, cmd_win, ctl_win, hit_cmd, hit_ctl, up_hit, lo_hit, rd_hit, wr_hit, chg_rd;
    // Expected decode from the current inputs
    always_comb begin
        up_next = {up_reg[0], 1'b1};
        wide = sixteen_bit_host_mode;
        cmd_win = wide ? (host_addr[9:3] == (secondary_set ? 7'h2E : 7'h3E))
                       : (host_addr[9:2] == 8'hC8);
        ctl_win = (wide && secondary_set) ? (host_addr[9:1] == 9'h1BB)
                                          : (host_addr[9:1] == 9'h1FB);
        hit_cmd = port_enable && !host_aen && cmd_win;
        hit_ctl = port_enable && !host_aen && ctl_win;
        up_hit = wide && hit_cmd && !wide_transfer_flag_n;
        lo_hit = hit_cmd || (wide && hit_ctl) || (port_enable && !wide && !wide_transfer_flag_n);
        rd_hit = wide && (hit_cmd || hit_ctl) && !host_ior_n;
        wr_hit = wide && (hit_cmd || hit_ctl) && !host_iow_n;
        chg_rd = rd_hit && hit_ctl && host_addr[0];
    end
    // Warm-up counter, checks start at the third edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            up_reg <= 2'h0;
        end else begin
            up_reg <= up_next;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_cmd_sel;
        up_reg[1] |-> drive_cmd_select_n == !$past(hit_cmd);
    endproperty
    a_cmd_sel: assert property (p_cmd_sel) else $error("command select wrong");
    property p_ctl_sel;
        up_reg[1] |-> drive_ctl_select_n == !$past(hit_ctl);
    endproperty
    a_ctl_sel: assert property (p_ctl_sel) else $error("control select wrong");
    property p_upper;
        up_reg[1] |-> drive_upper_byte_enable_n == !$past(up_hit);
    endproperty
    a_upper: assert property (p_upper) else $error("upper wrong");
    property p_lower;
        up_reg[1] |-> drive_lower_byte_enable_n == !$past(lo_hit);
    endproperty
    a_lower: assert property (p_lower) else $error("lower enable wrong");
    property p_disabled;
        up_reg[1] && !$past(port_enable) |-> drive_cmd_select_n && drive_ctl_select_n
            && drive_upper_byte_enable_n && drive_lower_byte_enable_n && drive_data_bit7_oe_n;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled port active");
    property p_read_buf;
        up_reg[1] && $past(rd_hit) |-> !host_d7_oe_n
            && host_d7_out == ($past(chg_rd) ? $past(disk_change) : $past(drive_data_bit7_in));
    endproperty
    a_read_buf: assert property (p_read_buf) else $error("host bit7 wrong");
    property p_write_buf;
        up_reg[1] && $past(wr_hit) |-> !drive_data_bit7_oe_n
            && drive_data_bit7_out == $past(host_d7_in);
    endproperty
    a_write_buf: assert property (p_write_buf) else $error("drive bit7 wrong");
    property p_narrow_idle;
        up_reg[1] && !$past(wide) |-> host_d7_oe_n && drive_data_bit7_oe_n;
    endproperty
    a_narrow_idle: assert property (p_narrow_idle) else $error("bit7 driven narrow");
    property p_strap_hold;
        up_reg[1] |-> $stable(secondary_set);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
endmodule : dpsd_checker

bind drive_port_select_decoder dpsd_checker dpsd_checker_inst (
    .clock(clock), .rst_n(rst_n), .port_enable(port_enable), .host_aen(host_aen),
    .sixteen_bit_host_mode(sixteen_bit_host_mode), .host_addr(host_addr),
    .host_ior_n(host_ior_n), .host_iow_n(host_iow_n), .host_d7_in(host_d7_in),
    .disk_change(disk_change), .wide_transfer_flag_n(wide_transfer_flag_n),
    .drive_data_bit7_in(drive_data_bit7_in), .host_d7_out(host_d7_out),
    .host_d7_oe_n(host_d7_oe_n), .drive_cmd_select_n(drive_cmd_select_n),
    .drive_ctl_select_n(drive_ctl_select_n), .secondary_set(secondary_set),
    .drive_upper_byte_enable_n(drive_upper_byte_enable_n),
    .drive_lower_byte_enable_n(drive_lower_byte_enable_n),
    .drive_data_bit7_out(drive_data_bit7_out), .drive_data_bit7_oe_n(drive_data_bit7_oe_n)
);

`default_nettype wire

// ### sim/dpsd_drive_model.sv
`default_nettype none

module dpsd_drive_model (
    // Clock
    input wire logic clock,
    // Selects from the decoder
    input wire logic cmd_sel_n,
    input wire logic ctl_sel_n,
    // Decoder side of bit 7
    input wire logic dev_d7,
    input wire logic dev_d7_oe_n,
    // Scenario controls
    input wire logic d7_value,
    input wire logic want_wide,
    input wire logic dma_ack_n,
    // Pins seen by the decoder
    output logic d7_wire,
    output logic flag_n
);
    logic last_reg = 1'b0; // Last wire level, for the released pattern
    // Decoder wins, else selected drive, else a toggling released line
    assign d7_wire = !dev_d7_oe_n ? dev_d7 : (!cmd_sel_n || !ctl_sel_n) ? d7_value : !last_reg;
    // Wide flag only while addressed; DMA ack shares the pin
    assign flag_n = !(want_wide && !cmd_sel_n) && dma_ack_n;
    always_ff @(posedge clock) begin
        last_reg <= d7_wire;
    end
endmodule : dpsd_drive_model

`default_nettype wire

// ### sim/drive_port_select_decoder_test.sv
`default_nettype none

module drive_port_select_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dpsd_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic port_enable = 1'b1;
    logic sixteen_bit_host_mode = 1'b1;
    logic drive_addr_strap = 1'b0;
    logic [DPSD_ADDR_W-1:0] host_addr = 10'h000;
    logic host_aen = 1'b0;
    logic host_ior_n = 1'b1;
    logic host_iow_n = 1'b1;
    logic host_d7_drv = 1'b0; // Host side value of bit 7
    logic disk_change = 1'b0;
    logic d7_value = 1'b0;
    logic want_wide = 1'b1;
    logic dma_ack_n = 1'b1;
    logic exp_sec = 1'b0; // Expected address set
    logic [9:0] alist [18] = '{10'h1F0, 10'h1F7, 10'h1EF, 10'h1F8, 10'h3F6, 10'h3F7, 10'h3F5,
        10'h3F8, 10'h320, 10'h323, 10'h324, 10'h31F, 10'h170, 10'h177, 10'h16F, 10'h376,
        10'h377, 10'h375};
    wire logic host_d7_in, host_d7_out, host_d7_oe_n, flag_n, d7_in, d7_out, d7_oe_n;
    wire logic cmd_n, ctl_n, upper_n, lower_n, secondary_set;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #2 clock = ~clock;
    assign host_d7_in = host_d7_oe_n ? host_d7_drv : host_d7_out; // Host wire level
    drive_port_select_decoder drive_port_select_decoder_inst (.clock(clock), .rst_n(rst_n),
        .port_enable(port_enable), .sixteen_bit_host_mode(sixteen_bit_host_mode),
        .drive_addr_strap(drive_addr_strap), .host_addr(host_addr), .host_aen(host_aen),
        .host_ior_n(host_ior_n), .host_iow_n(host_iow_n), .host_d7_in(host_d7_in),
        .host_d7_out(host_d7_out), .host_d7_oe_n(host_d7_oe_n), .disk_change(disk_change),
        .wide_transfer_flag_n(flag_n), .drive_cmd_select_n(cmd_n), .drive_ctl_select_n(ctl_n),
        .drive_upper_byte_enable_n(upper_n), .drive_lower_byte_enable_n(lower_n),
        .drive_data_bit7_in(d7_in), .drive_data_bit7_out(d7_out),
        .drive_data_bit7_oe_n(d7_oe_n), .secondary_set(secondary_set));
    dpsd_drive_model dpsd_drive_model_inst (.clock(clock), .cmd_sel_n(cmd_n), .ctl_sel_n(ctl_n),
        .dev_d7(d7_out), .dev_d7_oe_n(d7_oe_n), .d7_value(d7_value), .want_wide(want_wide),
        .dma_ack_n(dma_ack_n), .d7_wire(d7_in), .flag_n(flag_n));
    // ----------------------------------------
    // Compare, access and report tasks
    // ----------------------------------------
    task chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One host access held two edges, then selects, enables and bit-7 data compared
    task probe(input logic [9:0] a, input logic rd_n, input logic wr_n);
        logic w, dec, cmd, ctl, rdp, wrp, hx;
        logic [3:0] e;
        @(negedge clock);
        host_addr = a;
        host_ior_n = rd_n;
        host_iow_n = wr_n;
        d7_value = a[1];
        host_d7_drv = ~a[0];
        disk_change = a[2];
        repeat (2) @(negedge clock);
        w = sixteen_bit_host_mode;
        dec = port_enable && !host_aen;
        cmd = w ? (a[9:3] == (exp_sec ? 7'h2E : 7'h3E)) : (a[9:2] == 8'hC8);
        ctl = (w && exp_sec) ? (a[9:1] == 9'h1BB) : (a[9:1] == 9'h1FB);
        rdp = w && dec && (cmd || ctl) && !rd_n;
        wrp = w && dec && (cmd || ctl) && !wr_n;
        e[3] = !(dec && cmd);
        e[2] = !(dec && ctl);
        e[1] = !(w && dec && cmd && want_wide);
        e[0] = !(port_enable && ((dec && (cmd || (w && ctl))) || (!w && !dma_ack_n)));
        chk("selects", e, {cmd_n, ctl_n, upper_n, lower_n});
        chk("bit7 enables", {2'b00, !rdp, !wrp}, {2'b00, host_d7_oe_n, d7_oe_n});
        hx = (ctl && a[0]) ? a[2] : a[1];
        if (rdp) chk("host bit7", {3'b000, hx}, {3'b000, host_d7_out});
        if (wrp) chk("drive bit7", {3'b000, ~a[0]}, {3'b000, d7_out});
    endtask : probe
    task sweep();
        foreach (alist[i]) begin
            probe(alist[i], 1'b0, 1'b1);
            probe(alist[i], 1'b1, 1'b0);
        end
    endtask : sweep
    task final_report();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    // Hang guard
    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(negedge clock);
        chk("reset", 4'hF, {cmd_n, ctl_n, upper_n, lower_n});
        chk("reset status", 4'hC, {host_d7_oe_n, d7_oe_n, secondary_set, 1'b0});
        rst_n = 1'b1;
        sweep();
        want_wide = 1'b0;
        probe(10'h1F0, 1'b0, 1'b1);
        host_aen = 1'b1;
        probe(10'h1F0, 1'b0, 1'b1);
        host_aen = 1'b0;
        port_enable = 1'b0;
        probe(10'h1F0, 1'b0, 1'b1);
        probe(10'h3F7, 1'b1, 1'b0);
        port_enable = 1'b1;
        sixteen_bit_host_mode = 1'b0;
        sweep();
        dma_ack_n = 1'b0;
        probe(10'h200, 1'b1, 1'b1);
        host_aen = 1'b1;
        probe(10'h320, 1'b0, 1'b1);
        dma_ack_n = 1'b1;
        probe(10'h320, 1'b0, 1'b1);
        host_aen = 1'b0;
        rst_n = 1'b0;
        drive_addr_strap = 1'b1;
        sixteen_bit_host_mode = 1'b1;
        want_wide = 1'b1;
        exp_sec = 1'b1;
        repeat (2) @(negedge clock);
        chk("strap in reset", 4'h0, {3'b000, secondary_set});
        rst_n = 1'b1;
        drive_addr_strap = 1'b0;
        @(negedge clock);
        chk("strap", 4'h1, {3'b000, secondary_set});
        sweep();
        chk("strap held", 4'h1, {3'b000, secondary_set});
        final_report();
    end
endmodule : drive_port_select_decoder_test

`default_nettype wire
